// ===== hdl/cs_match.sv
`timescale 1ns/1ps
module cs_match
  import xmove_pkg::*;
(
  input  wire logic [15:0] addr, // Address of the move
  input  wire logic [15:0] base, // Base address of the pin
  input  wire logic [1:0]  cmp,  // Comparison width select
  output logic             hit   // Address falls in the window
);
  logic [15:0] mask;

  always_comb begin
    case (cmp)
      CMP_A16: mask = 16'hffff;
      CMP_A15: mask = 16'hfffe;
      CMP_A14: mask = 16'hfffc;
      CMP_A8:  mask = 16'hff00;
      default: mask = 16'hffff;
    endcase
    hit = ((addr ^ base) & mask) == 16'h0000;
  end
endmodule

// ===== hdl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk, // Core clock
  input  wire logic         rst_n,   // Synchronous reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous level
  output logic      [W-1:0] q        // Synchronised level
);
  logic [W-1:0] meta_r;

  // First stage feeds the second stage only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ===== hdl/xmove_cs.sv
`timescale 1ns/1ps
// Overview of operation
// - Stretch value 0..7 makes an external move last stretch+2 machine cycles.
// - The read or write strobe is lengthened by the programmed stretch.
// - Moves to on-chip data memory always take two machine cycles.
// - Stretch field resets to one, giving three-machine-cycle external moves.
// - Pin mode 00 makes the port-4 pin a plain general-purpose I/O bit.
// - Pin mode 01 gives a chip-select strobe on matching external reads.
// - Pin mode 10 gives a chip-select strobe on matching external writes.
// - Pin mode 11 gives a chip-select strobe on matching reads and writes.
// - Comparison 00 matches all sixteen address bits against the base.
// - Comparison 01 matches address bits 15 to 1, bit 0 ignored.
// - Comparison 10 matches address bits 15 to 2, two lowest ignored.
// - Comparison 11 matches address bits 15 to 8, a 256-byte block.
// - Each pin has its own mode, comparison and base, two per register.
// - Each base sits in a high byte and a low byte register.
module xmove_cs
  import xmove_pkg::*;
#(
  parameter int MC_CLKS = MC_CLKS_DEF
) (
  input  wire logic        ref_clk,         // Core clock, 10 MHz
  input  wire logic        rst_n,           // Synchronous reset, low
  input  wire logic [9:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire logic        mv_req,          // Move request pulse
  input  wire move_s       mv,              // Move descriptor
  output logic             mv_ready,        // Idle, request taken
  output logic             mv_done,         // Move finished pulse
  output logic      [7:0]  mv_rdata,        // Read result
  output logic      [15:0] ext_addr,        // External address
  output logic      [7:0]  ext_dout,        // External write data
  output logic             ext_dout_oe_n,   // Data drive enable, low
  input  wire logic [7:0]  ext_din,         // External read data
  output logic             ext_rd_n,        // Read strobe, low
  output logic             ext_wr_n,        // Write strobe, low
  input  wire logic [3:0]  p4_in,           // Port-4 pin levels
  output logic      [3:0]  p4_out,          // Port-4 pin drive value
  output logic      [3:0]  p4_oe_n          // Port-4 drive enable, low
);

  if (MC_CLKS < 1 || MC_CLKS > 16) begin : g_bad_clks
    $error("MC_CLKS must lie in 1..16");
  end

  localparam logic [7:0] SETUP_CNT = 8'(SETUP_MC * MC_CLKS - 1);
  localparam logic [7:0] INT_CNT   = 8'(INT_MOVE_MC * MC_CLKS - 1);

  logic [7:0]  stretch_ctl_r;
  logic [7:0]  p4con_r [2];
  logic [15:0] base_r  [4];
  logic [3:0]  gpio_r;
  pin_cfg_s    cfg     [4];
  logic [3:0]  hit;
  logic [3:0]  p4_in_s;
  logic [7:0]  ext_din_s;
  logic [7:0]  idx;
  logic        aligned;
  logic        wr_go;
  logic [31:0] rdata_nxt;
  logic [2:0]  stretch;
  logic [2:0]  mv_stretch_r;
  move_s       cur_r;
  move_state_e state_r;
  move_state_e state_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  strobe_cnt;
  logic        accept;
  logic        last;

  assign idx     = avs_address[9:2];
  assign aligned = avs_address[1:0] == 2'h0;
  // Write lands on the edge where the master sees waitrequest low
  assign wr_go   = avs_write && !avs_waitrequest && aligned;
  assign stretch = stretch_ctl_r[STRETCH_LSB +: 3];
  assign accept  = (state_r == ST_IDLE) && mv_req;
  assign last    = cnt_r == 8'h00;
  assign strobe_cnt = 8'((32'(mv_stretch_r) + STROBE_BASE_MC) * MC_CLKS - 1);

  sync2 #(.W(4)) u_sync_p4 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (p4_in),
    .q       (p4_in_s)
  );

  sync2 #(.W(8)) u_sync_din (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (ext_din),
    .q       (ext_din_s)
  );

  // Bus slave: one wait cycle, then the answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rdata_nxt;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        IDX_STRETCH_CTL: rdata_nxt[7:0] = stretch_ctl_r;
        IDX_SEL_CTL_A:   rdata_nxt[7:0] = p4con_r[0];
        IDX_SEL_CTL_B:   rdata_nxt[7:0] = p4con_r[1];
        IDX_GPIO:   rdata_nxt[3:0] = p4_in_s;
        IDX_STATUS: begin
          rdata_nxt[STAT_BUSY] = state_r != ST_IDLE;
          rdata_nxt[STAT_INT]  = cur_r.internal;
        end
        default:    rdata_nxt = 32'h0000_0000;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (idx == IDX_BASE_LO[i*8 +: 8])
          rdata_nxt[7:0] = base_r[i][7:0];
        if (idx == IDX_BASE_HI[i*8 +: 8])
          rdata_nxt[7:0] = base_r[i][15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stretch_ctl_r <= STRETCH_CTL_RST;
    end else if (wr_go && idx == IDX_STRETCH_CTL) begin
      stretch_ctl_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      p4con_r[0] <= P4CON_RST;
      p4con_r[1] <= P4CON_RST;
    end else if (wr_go && idx == IDX_SEL_CTL_A) begin
      p4con_r[0] <= avs_writedata[7:0];
    end else if (wr_go && idx == IDX_SEL_CTL_B) begin
      p4con_r[1] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gpio_r <= GPIO_RST;
    end else if (wr_go && idx == IDX_GPIO) begin
      gpio_r <= avs_writedata[3:0];
    end
  end

  // Move sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   if (mv_req) state_nxt = mv.internal ? ST_INT : ST_SETUP;
      ST_SETUP:  if (last) state_nxt = ST_STROBE;
      ST_STROBE: if (last) state_nxt = ST_IDLE;
      ST_INT:    if (last) state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (mv_req)
            cnt_r <= mv.internal ? INT_CNT : SETUP_CNT;
        end
        ST_SETUP: cnt_r <= last ? strobe_cnt : cnt_r - 8'h01;
        default:  cnt_r <= last ? 8'h00 : cnt_r - 8'h01;
      endcase
    end
  end

  // Stretch is frozen per move so a mid-move write cannot tear it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_r        <= '0;
      mv_stretch_r <= 3'h0;
      ext_addr     <= 16'h0000;
      ext_dout     <= 8'h00;
    end else if (accept) begin
      cur_r        <= mv;
      mv_stretch_r <= stretch;
      if (!mv.internal) begin
        ext_addr <= mv.addr;
        ext_dout <= mv.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_rd_n      <= 1'b1;
      ext_wr_n      <= 1'b1;
      ext_dout_oe_n <= 1'b1;
    end else begin
      ext_rd_n      <= !(state_nxt == ST_STROBE && !cur_r.wr);
      ext_wr_n      <= !(state_nxt == ST_STROBE && cur_r.wr);
      ext_dout_oe_n <= !(state_nxt == ST_STROBE && cur_r.wr);
    end
  end

  // Read data is sampled on the last clock of the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mv_done  <= 1'b0;
      mv_rdata <= 8'h00;
      mv_ready <= 1'b1;
    end else begin
      mv_done  <= (state_r == ST_STROBE || state_r == ST_INT) && last;
      mv_ready <= state_nxt == ST_IDLE;
      if (state_r == ST_STROBE && last && !cur_r.wr)
        mv_rdata <= ext_din_s;
    end
  end

  // Chip-select pins, one slice per pin
  for (genvar i = 0; i < 4; i++) begin : g_pin
    logic permit;

    assign cfg[i] = p4con_r[i/2][(i%2)*SLOT_W +: SLOT_W];

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        base_r[i] <= {BASE_RST, BASE_RST};
      end else if (wr_go && idx == IDX_BASE_LO[i*8 +: 8]) begin
        base_r[i][7:0] <= avs_writedata[7:0];
      end else if (wr_go && idx == IDX_BASE_HI[i*8 +: 8]) begin
        base_r[i][15:8] <= avs_writedata[7:0];
      end
    end

    cs_match u_match (
      .addr (cur_r.addr),
      .base (base_r[i]),
      .cmp  (cfg[i].cmp),
      .hit  (hit[i])
    );

    always_comb begin
      case (cfg[i].mode)
        MODE_RD: permit = !cur_r.wr;
        MODE_WR: permit = cur_r.wr;
        MODE_RW: permit = 1'b1;
        default: permit = 1'b0;
      endcase
    end

    // GPIO mode pulls low for a 0 and floats for a 1, like port 1
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        p4_out[i]  <= 1'b1;
        p4_oe_n[i] <= 1'b1;
      end else if (cfg[i].mode == MODE_GPIO) begin
        p4_out[i]  <= gpio_r[i];
        p4_oe_n[i] <= gpio_r[i];
      end else begin
        p4_out[i]  <= !(state_nxt == ST_STROBE && hit[i] && permit);
        p4_oe_n[i] <= 1'b0;
      end
    end

    // Pin value follows a mode write one edge late
    cs_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(cfg[i].mode) == MODE_RD && !p4_out[i])
      |-> !ext_rd_n && ext_wr_n)
      else $error("read select outside a read strobe");

    cs_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(cfg[i].mode) == MODE_WR && !p4_out[i])
      |-> !ext_wr_n && ext_rd_n)
      else $error("write select outside a write strobe");

    cs_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(cfg[i].mode) != MODE_GPIO && ext_rd_n && ext_wr_n)
      |-> p4_out[i])
      else $error("select active without a strobe");

    cs_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(cfg[i].mode) == MODE_RW && $past(hit[i])
       && $rose(ext_rd_n & ext_wr_n) == 1'b0 && $fell(ext_rd_n & ext_wr_n))
      |-> !p4_out[i])
      else $error("matching move gave no select");
  end

  // Helper counts for the timing checks below
  logic [7:0] len_r;
  logic [7:0] str_len_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      len_r     <= 8'h00;
      str_len_r <= 8'h00;
    end else begin
      len_r     <= (state_r == ST_IDLE) ? 8'h00 : len_r + 8'h01;
      if (!ext_rd_n || !ext_wr_n)
        str_len_r <= str_len_r + 8'h01;
      else if (accept)
        str_len_r <= 8'h00;
    end
  end

  stretch_rst_a: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> stretch == 3'h1)
    else $error("stretch not one after reset");

  move_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mv_done && !cur_r.internal)
    |-> 32'(len_r) == (32'(mv_stretch_r) + 2) * MC_CLKS)
    else $error("external move length wrong");

  strobe_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mv_done && !cur_r.internal)
    |-> 32'(str_len_r) == (32'(mv_stretch_r) + 1) * MC_CLKS)
    else $error("strobe length wrong");

  int_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mv_done && cur_r.internal)
    |-> 32'(len_r) == INT_MOVE_MC * MC_CLKS)
    else $error("internal move not two machine cycles");

  int_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == ST_INT) |=> ext_rd_n && ext_wr_n && ext_dout_oe_n)
    else $error("strobe during internal move");

endmodule

// ===== hdl/xmove_pkg.sv
package xmove_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0]  IDX_STRETCH_CTL = 8'h8e;
  localparam logic [7:0]  IDX_SEL_CTL_A   = 8'h92;
  localparam logic [7:0]  IDX_SEL_CTL_B   = 8'h93;
  localparam logic [31:0] IDX_BASE_LO = {8'h9c, 8'h9a, 8'h96, 8'h94};
  localparam logic [31:0] IDX_BASE_HI = {8'h9d, 8'h9b, 8'h97, 8'h95};
  localparam logic [7:0]  IDX_GPIO   = 8'ha5;
  localparam logic [7:0]  IDX_STATUS = 8'hbf;

  // Field positions
  localparam int STRETCH_LSB = 0;
  localparam int SLOT_W      = 4;
  localparam int CMP_LSB     = 0;
  localparam int MODE_LSB    = 2;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_INT    = 1;

  // Reset values
  localparam logic [7:0] STRETCH_CTL_RST = 8'h01;
  localparam logic [7:0] P4CON_RST = 8'h00;
  localparam logic [7:0] BASE_RST  = 8'h00;
  localparam logic [3:0] GPIO_RST  = 4'hf;

  // Timing: clocks per machine cycle, then lengths in machine cycles
  localparam int MC_CLKS_DEF   = 4;
  localparam int INT_MOVE_MC   = 2;
  localparam int SETUP_MC      = 1;
  localparam int STROBE_BASE_MC = 1;

  localparam logic [1:0] MODE_GPIO = 2'h0;
  localparam logic [1:0] MODE_RD   = 2'h1;
  localparam logic [1:0] MODE_WR   = 2'h2;
  localparam logic [1:0] MODE_RW   = 2'h3;
  localparam logic [1:0] CMP_A16   = 2'h0;
  localparam logic [1:0] CMP_A15   = 2'h1;
  localparam logic [1:0] CMP_A14   = 2'h2;
  localparam logic [1:0] CMP_A8    = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_INT    = 4'h8
  } move_state_e;

  typedef struct packed {
    logic        wr;
    logic        internal;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } move_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] cmp;
  } pin_cfg_s;

endpackage

// ===== verification/ext_mem.sv
`timescale 1ns/1ps
module ext_mem #(
  parameter int LAT = 0
) (
  input  wire logic        ref_clk,       // Core clock
  input  wire logic [15:0] ext_addr,      // Address from the device
  input  wire logic [7:0]  ext_dout,      // Write data from the device
  input  wire logic        ext_dout_oe_n, // Device drives data, low
  input  wire logic        ext_rd_n,      // Read strobe, low
  input  wire logic        ext_wr_n,      // Write strobe, low
  output logic      [7:0]  ext_din        // Read data to the device
);
  logic [7:0] mem [256];
  logic [7:0] last_q;
  int         lo_cnt;
  logic       valid;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_q = 8'h00;
    lo_cnt = 0;
  end

  // LAT above zero models a slow part
  assign valid = !ext_rd_n && lo_cnt >= LAT;

  always @(posedge ref_clk) begin
    if (!ext_wr_n && !ext_dout_oe_n)
      mem[ext_addr[7:0]] <= ext_dout;
    lo_cnt <= ext_rd_n ? 0 : lo_cnt + 1;
    if (valid)
      last_q <= mem[ext_addr[7:0]];
  end

  // Released bus shows no stale value
  assign ext_din = valid ? mem[ext_addr[7:0]] : ~last_q;
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import xmove_pkg::*;
  localparam int MC = 4;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        mv_req = 1'b0;
  move_s       mv = '0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, mv_ready, mv_done;
  logic        ext_dout_oe_n, ext_rd_n, ext_wr_n;
  logic [7:0]  mv_rdata, ext_dout, ext_din;
  logic [15:0] ext_addr;
  logic [3:0]  p4_in, p4_out, p4_oe_n;
  int          fails = 0;
  int          total_checks = 0;
  int          n_clk, n_stb;
  int          n_cs [4];

  always #50 ref_clk = ~ref_clk;
  // Pull-up on released pins
  assign p4_in = p4_out | p4_oe_n;

  xmove_cs #(.MC_CLKS(MC)) i_xmove_cs (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mv_req(mv_req), .mv(mv),
    .mv_ready(mv_ready), .mv_done(mv_done), .mv_rdata(mv_rdata),
    .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_dout_oe_n(ext_dout_oe_n), .ext_din(ext_din),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .p4_in(p4_in),
    .p4_out(p4_out), .p4_oe_n(p4_oe_n));

  ext_mem i_ext_mem (
    .ref_clk(ref_clk), .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_dout_oe_n(ext_dout_oe_n), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .ext_din(ext_din));

  task end_of_test;
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
    @(posedge ref_clk);
  endtask

  // Counts cycles up to the done pulse, strobe and select low cycles
  task move(input logic wr, input logic intl, input logic [15:0] a,
            input logic [7:0] d);
    int k;
    k = 0;
    n_clk = 0;
    n_stb = 0;
    n_cs = '{0, 0, 0, 0};
    mv <= {wr, intl, a, d};
    mv_req <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (mv_ready !== 1'b1 && k < 50);
    mv_req <= 1'b0;
    do begin
      @(posedge ref_clk);
      n_clk++;
      if (ext_rd_n === 1'b0 || ext_wr_n === 1'b0)
        n_stb++;
      for (int i = 0; i < 4; i++)
        if (p4_out[i] === 1'b0)
          n_cs[i]++;
    end while (mv_done !== 1'b1 && n_clk < 200);
    if (n_clk >= 200 || k >= 50) begin
      fails++;
      end_of_test();
    end
  endtask

  task cs_chk(input logic [3:0] mask);
    for (int i = 0; i < 4; i++)
      chk(n_cs[i], mask[i] ? MC : 0);
  endtask

  task t_reset;
    bus(1'b1, 8'h10, 8'h07);
    bus(1'b0, 8'h10, 8'h00);
    chk(rd, 32'h0);
    bus(1'b0, IDX_STRETCH_CTL, 8'h00);
    chk(rd, 32'h1);
    bus(1'b0, IDX_SEL_CTL_A, 8'h00);
    chk(rd, 32'h0);
    chk(p4_oe_n, 4'hf);
    move(1'b1, 1'b0, 16'h0001, 8'h5a);
    chk(n_clk, 3 * MC + 1);
  endtask

  task t_stretch;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, IDX_STRETCH_CTL, 8'(s));
      move(1'b1, 1'b0, 16'h0040 + 16'(s), 8'ha0 + 8'(s));
      chk(n_clk, (s + 2) * MC + 1);
      chk(n_stb, (s + 1) * MC);
    end
    // Maximum stretch must not reach internal moves
    move(1'b0, 1'b1, 16'h0040, 8'h00);
    chk(n_clk, 2 * MC + 1);
    chk(n_stb, 0);
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(rd, 32'h2);
    bus(1'b1, IDX_STRETCH_CTL, 8'h00);
    move(1'b0, 1'b0, 16'h0043, 8'h00);
    chk(mv_rdata, 8'ha3);
  endtask

  task t_modes;
    for (int i = 0; i < 4; i++)
      bus(1'b1, IDX_BASE_HI[8*i +: 8], 8'h12);
    bus(1'b1, IDX_SEL_CTL_A, 8'hb7);
    bus(1'b1, IDX_SEL_CTL_B, 8'h0f);
    // Pins take the new mode one edge after the write lands
    @(posedge ref_clk);
    chk(p4_oe_n, 4'h8);
    move(1'b0, 1'b0, 16'h1250, 8'h00);
    cs_chk(4'b0101);
    move(1'b1, 1'b0, 16'h12aa, 8'h3c);
    cs_chk(4'b0110);
    move(1'b0, 1'b0, 16'h1350, 8'h00);
    cs_chk(4'b0000);
    move(1'b1, 1'b1, 16'h1250, 8'h00);
    cs_chk(4'b0000);
  endtask

  task t_cmp;
    logic [15:0] adr [5];
    adr = '{16'h1234, 16'h1235, 16'h1237, 16'h12ff, 16'h1334};
    bus(1'b1, IDX_BASE_LO[7:0], 8'h34);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_SEL_CTL_A, {4'h0, MODE_RW, 2'(c)});
      for (int k = 0; k < 5; k++) begin
        move(1'b0, 1'b0, adr[k], 8'h00);
        chk(n_cs[0], (k < 4 && k <= c) ? MC : 0);
      end
    end
  endtask

  task t_gpio;
    bus(1'b1, IDX_SEL_CTL_A, 8'h00);
    bus(1'b1, IDX_SEL_CTL_B, 8'h00);
    bus(1'b1, IDX_GPIO, 8'h0a);
    @(posedge ref_clk);
    chk(p4_out, 4'ha);
    chk(p4_oe_n, 4'ha);
    repeat (3) @(posedge ref_clk);
    bus(1'b0, IDX_GPIO, 8'h00);
    chk(rd[3:0], 4'ha);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_stretch();
    t_modes();
    t_cmp();
    t_gpio();
    end_of_test();
  end
endmodule
